// ===== asrf_defs.vh
`ifndef ASRF_DEFS_VH
`define ASRF_DEFS_VH
// Number of leading zeros ahead of the result in every frame.
`define ASRF_LEAD_ZEROS 5'h04
// Falling edge, counted from chip select low, that returns track to hold.
`define ASRF_HOLD_EDGE 5'h03
// Frame lengths in serial clocks for the three resolutions.
`define ASRF_FRAME_12B 5'h10
`define ASRF_FRAME_10B 5'h0e
`define ASRF_FRAME_8B 5'h0c
// Resolution in bits of the widest variant.
`define ASRF_RES_MAX 12
// Width of the falling edge counter.
`define ASRF_CNT_W 5
`endif

// ===== asrf_sync.v
`default_nettype none
// Two flip-flop synchroniser for one asynchronous level.
module asrf_sync
(
   input wire clk,
   input wire rst,
   input wire async_in,
   output reg sync_out
);
   reg meta_reg; // First stage, read only by the second stage.

   ////////////////////////////////////////////////////////////////////////
   // Both stages reset to the idle high level of the link pins, so no
   // false edge is seen when reset is released.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= 1'b1;
         sync_out <= 1'b1;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // asrf_sync
`default_nettype wire

// ===== asrf_framer.v
`include "asrf_defs.vh"
`default_nettype none
// Function
// - Chip select fall powers up, tracks, drives, converts.
// - Third serial clock fall returns track to hold.
// - Twelve-bit: sixteenth fall releases output, powers down.
// - Twelve-bit: early chip select rise aborts frame.
// - Ten-bit: fourteenth fall releases output, powers down.
// - Ten-bit: early chip select rise aborts frame.
// - Eight-bit: twelfth fall releases output, powers down.
// - Eight-bit: early chip select rise aborts frame.
// - Serial clock alone paces conversion and shifting.
// - First leading zero appears at chip select fall.
// - Each falling edge launches the next bit.
// - Last bit launched on second-last fall.
// - Result is straight unsigned binary.
module asrf_framer
#(
   parameter RES_BITS = `ASRF_RES_MAX
)
(
   input wire core_clk,
   input wire rst,
   input wire cs_n,
   input wire sclk,
   input wire [RES_BITS-1:0] sample_code,
   output reg serial_data_out,
   output reg serial_data_oe_n,
   output reg track_mode,
   output reg powered_up,
   output reg converting,
   output reg [RES_BITS-1:0] result_code,
   output reg result_valid
);
   // Frame length follows the resolution: four zeros plus the code bits.
   localparam [`ASRF_CNT_W-1:0] FRAME_LEN = (RES_BITS == 12) ?
      `ASRF_FRAME_12B : (RES_BITS == 10) ? `ASRF_FRAME_10B :
      `ASRF_FRAME_8B;
   // Fall on which the sample is taken and the code is loaded.
   localparam [`ASRF_CNT_W-1:0] HOLD_EDGE = `ASRF_HOLD_EDGE;
   // The fall counter never passes FRAME_LEN, so five bits suffice.

   // Frame states.
   localparam [1:0] ST_DOWN = 2'h0;
   localparam [1:0] ST_ACTIVE = 2'h1;
   localparam [1:0] ST_DONE = 2'h2;

   wire cs_n_s; // Synchronised chip select.
   wire sclk_s; // Synchronised serial clock.
   reg cs_n_d_reg; // Previous chip select sample.
   reg sclk_d_reg; // Previous serial clock sample.
   reg [1:0] state_reg; // Frame state.
   reg [`ASRF_CNT_W-1:0] edge_cnt_reg; // Falling edges seen in frame.
   reg [15:0] shift_reg; // Outgoing frame, next bit at the top.
   reg [RES_BITS-1:0] code_reg; // Sampled code held for the frame.

   wire cs_fall = cs_n_d_reg & ~cs_n_s;
   wire cs_rise = ~cs_n_d_reg & cs_n_s;
   wire sclk_fall = sclk_d_reg & ~sclk_s;

   // Returns the frame word: leading zeros, code MSB first, padded low.
   // Narrow codes are zero extended and then moved up against the zeros,
   // which avoids a zero-width replication in the twelve-bit build.
   function [15:0] frame_word;
      input [RES_BITS-1:0] code;
      begin
         frame_word = {{(16 - RES_BITS){1'b0}}, code}
            << (12 - RES_BITS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Both link pins cross into the core clock before any logic reads them.
   asrf_sync u_cs_sync
   (
      .clk(core_clk),
      .rst(rst),
      .async_in(cs_n),
      .sync_out(cs_n_s)
   );

   asrf_sync u_sclk_sync
   (
      .clk(core_clk),
      .rst(rst),
      .async_in(sclk),
      .sync_out(sclk_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Edge history of the synchronised pins.
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cs_n_d_reg <= 1'b1;
         sclk_d_reg <= 1'b1;
      end
      else
      begin
         cs_n_d_reg <= cs_n_s;
         sclk_d_reg <= sclk_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer; progress moves only on serial clock falls.
   // The first zero stands from chip select fall, the next three zeros
   // leave on falls one to three, and the code follows from fall four.
   // The release fall powers down; later falls are ignored until the
   // next chip select fall.
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ST_DOWN;
         edge_cnt_reg <= 5'h00;
         shift_reg <= 16'h0000;
         code_reg <= {RES_BITS{1'b0}};
         serial_data_out <= 1'b0;
         serial_data_oe_n <= 1'b1;
         track_mode <= 1'b0;
         powered_up <= 1'b0;
         converting <= 1'b0;
         result_code <= {RES_BITS{1'b0}};
         result_valid <= 1'b0;
      end
      else
      begin
         result_valid <= 1'b0;
         if (cs_fall)
         begin
            // A new frame starts from any state.
            state_reg <= ST_ACTIVE;
            edge_cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b0;
            track_mode <= 1'b1;
            powered_up <= 1'b1;
            converting <= 1'b1;
         end
         else
         begin
            case (state_reg)
               ST_ACTIVE:
               begin
                  if (cs_rise)
                  begin
                     // Early chip select rise aborts the conversion.
                     state_reg <= ST_DOWN;
                     serial_data_oe_n <= 1'b1;
                     track_mode <= 1'b0;
                     powered_up <= 1'b0;
                     converting <= 1'b0;
                  end
                  else if (sclk_fall)
                  begin
                     edge_cnt_reg <= edge_cnt_reg + 5'h01;
                     if (edge_cnt_reg + 5'h01 == HOLD_EDGE)
                     begin
                        // Sample taken: code captured as hold begins.
                        track_mode <= 1'b0;
                        code_reg <= sample_code;
                        // The four zeros are already out; the MSB goes next.
                        shift_reg <= frame_word(sample_code)
                           << `ASRF_LEAD_ZEROS;
                     end
                     else
                     begin
                        shift_reg <= {shift_reg[14:0], 1'b0};
                     end
                     // Bit n+1 launched on fall n; zeros before hold.
                     if (edge_cnt_reg + 5'h01 < HOLD_EDGE)
                     begin
                        serial_data_out <= 1'b0;
                     end
                     else if (edge_cnt_reg + 5'h01 == HOLD_EDGE)
                     begin
                        serial_data_out <= 1'b0;
                     end
                     else
                     begin
                        serial_data_out <= shift_reg[15];
                     end
                     if (edge_cnt_reg + 5'h01 == FRAME_LEN)
                     begin
                        state_reg <= ST_DONE;
                        serial_data_oe_n <= 1'b1;
                        powered_up <= 1'b0;
                        converting <= 1'b0;
                        result_code <= code_reg;
                        result_valid <= 1'b1;
                     end
                  end
               end
               ST_DONE:
               begin
                  // Powered down; clocks ignored until next frame.
                  if (cs_rise)
                  begin
                     state_reg <= ST_DOWN;
                  end
               end
               ST_DOWN:
               begin
                  state_reg <= ST_DOWN;
               end
               default:
               begin
                  state_reg <= ST_DOWN;
               end
            endcase
         end
      end
   end
endmodule // asrf_framer
`default_nettype wire

// ===== asrf_framer_assertions.sv
`default_nettype none
// Pin-level checks of one conversion frame.
module asrf_framer_chk
#(
   parameter RES_BITS = 12
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [RES_BITS-1:0] sample_code,
   input wire logic serial_data_out,
   input wire logic serial_data_oe_n,
   input wire logic track_mode,
   input wire logic powered_up,
   input wire logic converting,
   input wire logic [RES_BITS-1:0] result_code,
   input wire logic result_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FL = RES_BITS + 4;
   logic [4:0] fall_cnt; // Raw serial clock falls in this frame.
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Counts falls at the pin while chip select is low.
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
         fall_cnt <= 5'h00;
      else if (cs_n)
         fall_cnt <= 5'h00;
      else if ($fell(sclk))
         fall_cnt <= fall_cnt + 5'h01;
   end
   start_drive_a: assert property ($fell(cs_n) |-> ##[2:6]
      (!serial_data_oe_n && !serial_data_out && track_mode))
      else $error("no start");
   abort_off_a: assert property ($rose(cs_n) |-> ##[1:6]
      (serial_data_oe_n && !powered_up)) else $error("no abort");
   hold_edge_a: assert property ($fell(track_mode) && !cs_n |->
      fall_cnt == 5'h03) else $error("hold on wrong edge");
   end_edge_a: assert property ($rose(serial_data_oe_n) && !cs_n |->
      fall_cnt == 5'(FL)) else $error("release on wrong edge");
   shift_edge_a: assert property (sclk && $past(sclk, 3) &&
      !serial_data_oe_n && !$past(serial_data_oe_n, 2) |->
      $stable(serial_data_out)) else $error("data moved off a fall");
   off_idle_a: assert property (cs_n && $past(cs_n, 6) |->
      serial_data_oe_n && !powered_up && !converting) else $error("awake");
   code_out_a: assert property (result_valid |->
      serial_data_oe_n && result_code == sample_code) else $error("bad code");
   stay_off_a: assert property (fall_cnt > 5'(FL) |->
      serial_data_oe_n && !powered_up) else $error("woke on clock");
   cover property ($rose(cs_n) && !serial_data_oe_n);
   cover property (result_valid);
   cover property (fall_cnt > 5'(FL));
endmodule // asrf_framer_chk
bind asrf_framer asrf_framer_chk #(.RES_BITS(RES_BITS)) u_asrf_framer_chk (
   .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
   .sample_code(sample_code), .serial_data_out(serial_data_out),
   .serial_data_oe_n(serial_data_oe_n), .track_mode(track_mode),
   .powered_up(powered_up), .converting(converting),
   .result_code(result_code), .result_valid(result_valid));
`default_nettype wire

// ===== asrf_host.sv
`default_nettype none
// Host serial port: frames chip select, makes a 200 ns serial clock.
module asrf_host
(
   input wire logic core_clk,
   input wire logic sdo,
   output var logic cs_n,
   output var logic sclk
);
   timeunit 1ns;
   timeprecision 1ps;
   // The clock idles high and stands still outside frames.
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
   end
   // Runs n clocks; bits are taken at falls, or at rises when rise is set.
   // A rising-edge host still takes the first zero at the first fall.
   task automatic frame(input int n, input bit lift, input bit rise,
      output logic [15:0] w);
      w = 16'h0000;
      @(posedge core_clk) cs_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      cs_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < n; i++)
      begin
         if (!rise || i == 0)
            w = {w[14:0], sdo};
         sclk <= 1'b0;
         repeat (4) @(posedge core_clk);
         if (rise && i < n - 1)
            w = {w[14:0], sdo};
         sclk <= 1'b1;
         repeat (4) @(posedge core_clk);
      end
      if (lift)
         cs_n <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask
endmodule // asrf_host
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst, cs_n, sclk, serial_data_out, serial_data_oe_n;
   logic track_mode, powered_up, converting, result_valid;
   logic [11:0] sample_code, result_code;
   logic [15:0] word; // Bits captured by the host.
   int fail_count = 0;
   int checked = 0;
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   asrf_framer #(.RES_BITS(12)) u_asrf_framer (.core_clk(core_clk),
      .rst(rst), .cs_n(cs_n), .sclk(sclk), .sample_code(sample_code),
      .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
      .track_mode(track_mode), .powered_up(powered_up),
      .converting(converting), .result_code(result_code),
      .result_valid(result_valid));
   asrf_host u_asrf_host (.core_clk(core_clk), .sdo(serial_data_out),
      .cs_n(cs_n), .sclk(sclk));
   task check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task conclude();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Full frames: four zeros, the code MSB first, then release.
   task full_frames();
      logic [11:0] codes [4] = '{12'h000, 12'hfff, 12'ha5c, 12'h801};
      u_asrf_host.frame(16, 1'b1, 1'b0, word);
      foreach (codes[i])
      begin
         sample_code <= codes[i];
         u_asrf_host.frame(16, 1'b1, 1'b0, word);
         check(word, {4'h0, codes[i]});
         check(result_code, codes[i]);
         check({serial_data_oe_n, powered_up}, 2'b10);
      end
   endtask
   // Chip select rises after five clocks; the old result must stay.
   task abort_frame();
      u_asrf_host.frame(5, 1'b1, 1'b0, word);
      check(word, 16'h0001);
      check({serial_data_oe_n, powered_up, converting}, 3'b100);
      check(result_code, 12'h801);
   endtask
   // Extra clocks with chip select held low must not wake the part.
   task keep_low();
      sample_code <= 12'h35a;
      u_asrf_host.frame(19, 1'b0, 1'b0, word);
      check({serial_data_oe_n, powered_up, converting}, 3'b100);
      check(result_code, 12'h35a);
   endtask
   // Rising-edge capture: the first zero is taken at the first fall.
   task rise_frame();
      sample_code <= 12'hc93;
      u_asrf_host.frame(16, 1'b1, 1'b1, word);
      check(word, 16'h0c93);
      check(result_code, 12'hc93);
   endtask
   initial
   begin
      rst = 1'b1;
      sample_code = 12'h000;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      full_frames();
      abort_frame();
      keep_low();
      rise_frame();
      conclude();
   end
   // Cuts a hang short well past the expected run length.
   initial
   begin
      #200000;
      fail_count++;
      conclude();
   end
endmodule // tb
`default_nettype wire
